// ---- pkg/pci_cfg_pkg.sv ----
package pci_cfg_pkg;
  // Bus widths.
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  // Command codes on the command/byte-enable lines.
  localparam logic [3:0] CMD_IO_RD = 4'h2;
  localparam logic [3:0] CMD_IO_WR = 4'h3;
  localparam logic [3:0] CMD_CFG_RD = 4'hA;
  localparam logic [3:0] CMD_CFG_WR = 4'hB;
  localparam int CMD_WRITE_BIT = 0;
  localparam logic [3:0] BE_ALL_N = 4'h0;
  // Type-zero configuration address fields.
  localparam int TYPE_MSB = 1;
  localparam int TYPE_LSB = 0;
  localparam logic [1:0] TYPE_ZERO = 2'h0;
  localparam int DW_MSB = 7;
  localparam int DW_LSB = 2;
  localparam int FUNC_MSB = 10;
  localparam int FUNC_LSB = 8;
  // Last doubleword answered internally (offset 40h).
  localparam logic [5:0] CFG_LAST_DW = 6'h10;
  localparam int CFG_DEPTH = 17;
  localparam int CFG_AW = 5;
  // I/O window of 256 bytes: address bits above this are compared.
  localparam int IO_LSB = 8;
  // Packed pin sample vector layout and its reset value (all strobes idle).
  localparam int PIN_W = 39;
  localparam int PIN_FRAME = 38;
  localparam int PIN_IDSEL = 37;
  localparam int PIN_IRDY = 36;
  localparam int PIN_CBE_MSB = 35;
  localparam int PIN_CBE_LSB = 32;
  localparam logic [38:0] PIN_RESET = 39'h5F_0000_0000;
  localparam logic [31:0] AD_RESET = 32'h0000_0000;
endpackage : pci_cfg_pkg

// ---- rtl/cfg_dword_ram.sv ----
`timescale 1ns/1ps
module cfg_dword_ram #(
  parameter int WIDTH = pci_cfg_pkg::DATA_W,
  parameter int DEPTH = pci_cfg_pkg::CFG_DEPTH,
  parameter int AW = pci_cfg_pkg::CFG_AW
) (
  // Clock, reset and enable.
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Write port.
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  // Read port.
  input wire logic re_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o
);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] rdata_reg;
  logic [WIDTH-1:0] rdata_next;

  // Addresses past the array read as zero rather than wrapping.
  always_comb begin
    rdata_next = rdata_reg;
    if (re_i) begin
      rdata_next = (int'(raddr_i) < DEPTH) ? mem_reg[raddr_i] : '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (ce_i && we_i && (int'(waddr_i) < DEPTH)) begin
      mem_reg[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg <= '0;
    end else if (ce_i) begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;
endmodule : cfg_dword_ram

// ---- rtl/pci_target_cfg_io.sv ----
`timescale 1ns/1ps
// Behaviour
// - Header doublewords 00h through 40h are read and written internally, back-end untouched.
// - Configuration registers accept only full 32-bit, single data phase accesses.
// - Configuration accesses above 40h go to the local target interface.
// - Address bits 1:0 are 00, 7:2 doubleword, 10:8 function, rest ignored.
// - Decoding starts the clock after the address phase and lasts two clocks.
// - Slow select timing asserts devsel in the fourth clock of the transaction.
// - On reads the device asserts trdy and drives the selected doubleword.
// - Stop accompanies trdy in every configuration data clock.
// - A configuration write stores the doubleword in the trdy clock.
// - After the handshake devsel, trdy and stop deassert and read data is released.
// - One clock later devsel, trdy and stop are tri-stated.
// - I/O space accesses are claimed and sequenced like basic target accesses.
module pci_target_cfg_io (
  // Clock, reset and enable.
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // Bus inputs.
  input wire logic frame_n_i,
  input wire logic idsel_i,
  input wire logic irdy_n_i,
  input wire logic [3:0] cbe_n_i,
  input wire logic [31:0] ad_i,
  // Bus outputs, enables low while driven.
  output logic [31:0] ad_o,
  output logic ad_oe_n_o,
  output logic devsel_n_o,
  output logic devsel_oe_n_o,
  output logic trdy_n_o,
  output logic trdy_oe_n_o,
  output logic stop_n_o,
  output logic stop_oe_n_o,
  // I/O window setup.
  input wire logic io_en_i,
  input wire logic [23:0] io_base_i,
  // Local target interface.
  output logic lt_sel_o,
  output logic lt_io_o,
  output logic lt_write_o,
  output logic [31:0] lt_addr_o,
  output logic [3:0] lt_be_n_o,
  output logic [31:0] lt_wdata_o,
  output logic lt_xfer_o,
  input wire logic [31:0] lt_rdata_i,
  input wire logic lt_ready_i,
  input wire logic lt_abort_i
);
  typedef enum logic [2:0] {IDLE, DEC1, DEC2, DEVSEL, DATA, ABORT, TURN} state_t;

  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic frame_f, idsel_f, irdy_f;
  logic [3:0] cbe_f;
  logic [31:0] ad_f;

  state_t state_reg, state_next;
  logic [31:0] addr_reg, addr_next, ad_out_reg, ad_out_next, wdata_reg, wdata_next;
  logic [3:0] be_reg, be_next;
  logic cfg_reg, cfg_next, local_reg, local_next, write_reg, write_next;
  logic frame_d_reg, frame_d_next, xfer_reg, xfer_next, lt_sel_reg, lt_sel_next;
  logic devsel_n_reg, devsel_n_next, trdy_n_reg, trdy_n_next, stop_n_reg, stop_n_next;
  logic tgt_oe_n_reg, tgt_oe_n_next, ad_oe_n_reg, ad_oe_n_next;
  logic addr_phase, claim_cfg, claim_io, cfg_int, hs, mem_we;
  logic [31:0] ram_rdata;

  // The reset release is synchronised so that every flop leaves reset on the same edge.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync_reg <= 2'h0;
    end else if (ce_i) begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // Bus pins share the bus clock, so they are used as sampled; a synchroniser would push devsel
  // past the slow-select clock and would swallow the one-clock address phase.
  assign frame_f = frame_n_i;
  assign idsel_f = idsel_i;
  assign irdy_f = irdy_n_i;
  assign cbe_f = cbe_n_i;
  assign ad_f = ad_i;

  // Address phase is the first clock with frame seen asserted.
  assign addr_phase = (state_reg == IDLE) && frame_d_reg && !frame_f;
  assign claim_cfg = addr_phase && idsel_f && ad_f[pci_cfg_pkg::TYPE_MSB:pci_cfg_pkg::TYPE_LSB] == pci_cfg_pkg::TYPE_ZERO
    && (cbe_f == pci_cfg_pkg::CMD_CFG_RD || cbe_f == pci_cfg_pkg::CMD_CFG_WR);
  assign claim_io = addr_phase && io_en_i && ad_f[31:pci_cfg_pkg::IO_LSB] == io_base_i
    && (cbe_f == pci_cfg_pkg::CMD_IO_RD || cbe_f == pci_cfg_pkg::CMD_IO_WR);
  assign cfg_int = ad_f[pci_cfg_pkg::DW_MSB:pci_cfg_pkg::DW_LSB] <= pci_cfg_pkg::CFG_LAST_DW;
  assign hs = (state_reg == DATA) && !irdy_f;
  // Partial byte enables on an internal register are completed but not stored.
  assign mem_we = hs && !local_reg && write_reg && cbe_f == pci_cfg_pkg::BE_ALL_N;

  always_comb begin
    state_next = state_reg;
    addr_next = addr_reg;
    cfg_next = cfg_reg;
    local_next = local_reg;
    write_next = write_reg;
    ad_out_next = ad_out_reg;
    frame_d_next = frame_f;
    unique case (state_reg)
      IDLE: begin
        if (claim_cfg || claim_io) begin
          state_next = DEC1;
          addr_next = ad_f;
          cfg_next = claim_cfg;
          local_next = !(claim_cfg && cfg_int);
          write_next = cbe_f[pci_cfg_pkg::CMD_WRITE_BIT];
        end
      end
      DEC1: state_next = DEC2;
      DEC2: state_next = DEVSEL;
      DEVSEL: begin
        if (!local_reg) begin
          state_next = DATA;
          ad_out_next = ram_rdata;
        end else if (lt_abort_i) begin
          state_next = ABORT;
        end else if (lt_ready_i) begin
          state_next = DATA;
          ad_out_next = lt_rdata_i;
        end
      end
      DATA: begin
        if (!irdy_f) begin
          state_next = TURN;
        end
      end
      ABORT: begin
        if (frame_f) begin
          state_next = TURN;
        end
      end
      TURN: state_next = IDLE;
    endcase
  end

  always_comb begin
    wdata_next = hs ? ad_f : wdata_reg;
    be_next = hs ? cbe_f : be_reg;
    xfer_next = hs && local_reg;
    lt_sel_next = local_next && !(state_next inside {IDLE, TURN});
    devsel_n_next = !(state_next inside {DEVSEL, DATA});
    trdy_n_next = !(state_next == DATA);
    // A target abort shows stop with devsel released.
    stop_n_next = !((state_next == DATA && cfg_next) || state_next == ABORT);
    tgt_oe_n_next = !(state_next inside {DEVSEL, DATA, ABORT, TURN});
    ad_oe_n_next = !(state_next == DATA && !write_next);
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= IDLE;
      addr_reg <= pci_cfg_pkg::AD_RESET;
      cfg_reg <= 1'b0;
      local_reg <= 1'b0;
      write_reg <= 1'b0;
      ad_out_reg <= pci_cfg_pkg::AD_RESET;
      frame_d_reg <= 1'b1;
      wdata_reg <= pci_cfg_pkg::AD_RESET;
      be_reg <= 4'hF;
      xfer_reg <= 1'b0;
      lt_sel_reg <= 1'b0;
      devsel_n_reg <= 1'b1;
      trdy_n_reg <= 1'b1;
      stop_n_reg <= 1'b1;
      tgt_oe_n_reg <= 1'b1;
      ad_oe_n_reg <= 1'b1;
    end else if (ce_i) begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      cfg_reg <= cfg_next;
      local_reg <= local_next;
      write_reg <= write_next;
      ad_out_reg <= ad_out_next;
      frame_d_reg <= frame_d_next;
      wdata_reg <= wdata_next;
      be_reg <= be_next;
      xfer_reg <= xfer_next;
      lt_sel_reg <= lt_sel_next;
      devsel_n_reg <= devsel_n_next;
      trdy_n_reg <= trdy_n_next;
      stop_n_reg <= stop_n_next;
      tgt_oe_n_reg <= tgt_oe_n_next;
      ad_oe_n_reg <= ad_oe_n_next;
    end
  end

  cfg_dword_ram u_cfg_ram (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .ce_i(ce_i),
    .we_i(mem_we),
    .waddr_i(addr_reg[6:2]),
    .wdata_i(ad_f),
    .re_i(state_reg == DEC1),
    .raddr_i(addr_reg[6:2]),
    .rdata_o(ram_rdata)
  );

  assign ad_o = ad_out_reg;
  assign ad_oe_n_o = ad_oe_n_reg;
  assign devsel_n_o = devsel_n_reg;
  assign devsel_oe_n_o = tgt_oe_n_reg;
  assign trdy_n_o = trdy_n_reg;
  assign trdy_oe_n_o = tgt_oe_n_reg;
  assign stop_n_o = stop_n_reg;
  assign stop_oe_n_o = tgt_oe_n_reg;
  assign lt_sel_o = lt_sel_reg;
  assign lt_io_o = !cfg_reg;
  assign lt_write_o = write_reg;
  assign lt_addr_o = addr_reg;
  assign lt_be_n_o = be_reg;
  assign lt_wdata_o = wdata_reg;
  assign lt_xfer_o = xfer_reg;

  devsel_slow_a: assert property (@(posedge core_clk_i) disable iff (!rst_n || !ce_i)
    (claim_cfg && cfg_int) |-> ##3 (!devsel_n_o && !devsel_oe_n_o && trdy_n_o))
    else $error("devsel not asserted in the fourth clock");
  read_data_a: assert property (@(posedge core_clk_i) disable iff (!rst_n || !ce_i)
    (claim_cfg && cfg_int && !cbe_f[0]) |-> ##4 (!trdy_n_o && !ad_oe_n_o))
    else $error("configuration read data clock missing");
  cfg_stop_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (!trdy_n_o && cfg_reg) |-> !stop_n_o)
    else $error("stop missing with trdy on configuration access");
  release_after_a: assert property (@(posedge core_clk_i) disable iff (!rst_n || !ce_i)
    (!trdy_n_o && !irdy_f) |=> (devsel_n_o && trdy_n_o && stop_n_o && ad_oe_n_o && !trdy_oe_n_o))
    else $error("signals not released after handshake");
  tristate_idle_a: assert property (@(posedge core_clk_i) disable iff (!rst_n || !ce_i)
    (!trdy_n_o && !irdy_f) |-> ##2 (devsel_oe_n_o && trdy_oe_n_o && stop_oe_n_o))
    else $error("outputs not tri-stated after turnaround");
  cfg_store_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (hs && cfg_reg && !local_reg && write_reg && cbe_f == 4'h0) |-> (mem_we && !trdy_n_o))
    else $error("configuration write not stored in trdy clock");
  full_word_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    mem_we |-> (cbe_f == 4'h0 && !irdy_f && !trdy_n_o))
    else $error("partial configuration write stored");
  internal_only_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (cfg_reg && !local_reg) |-> !lt_sel_o && !lt_xfer_o)
    else $error("back-end involved in internal header access");
  upper_local_a: assert property (@(posedge core_clk_i) disable iff (!rst_n || !ce_i)
    (claim_cfg && !cfg_int) |-> ##2 lt_sel_o)
    else $error("upper configuration access not forwarded");
  decode_span_a: assert property (@(posedge core_clk_i) disable iff (!rst_n || !ce_i)
    (claim_cfg || claim_io) |=> (state_reg == DEC1) ##1 (state_reg == DEC2) ##1 (state_reg == DEVSEL))
    else $error("decode does not span two clocks");
  no_claim_a: assert property (@(posedge core_clk_i) disable iff (!rst_n || !ce_i)
    (addr_phase && !idsel_f && !claim_io) |=> (state_reg == IDLE && devsel_oe_n_o))
    else $error("claimed without idsel");
  io_claim_a: assert property (@(posedge core_clk_i) disable iff (!rst_n || !ce_i)
    claim_io |-> ##2 (lt_sel_o && lt_io_o) ##1 !devsel_n_o)
    else $error("I/O access not sequenced");
  addr_take_a: assert property (@(posedge core_clk_i) disable iff (!rst_n || !ce_i)
    claim_cfg |=> (lt_addr_o == $past(ad_f)))
    else $error("configuration address not captured");
  read_word_a: assert property (@(posedge core_clk_i) disable iff (!rst_n || !ce_i)
    (state_reg == DEVSEL && !local_reg) |=> (ad_o == $past(ram_rdata)))
    else $error("read data is not the selected doubleword");
  read_drive_a: assert property (@(posedge core_clk_i) disable iff (!rst_n || !ce_i)
    (!trdy_n_o && !write_reg) |-> !ad_oe_n_o)
    else $error("read data not driven with trdy");
  write_float_a: assert property (@(posedge core_clk_i) disable iff (!rst_n || !ce_i)
    (!trdy_n_o && write_reg) |-> ad_oe_n_o)
    else $error("data lines driven during a write");
  io_no_stop_a: assert property (@(posedge core_clk_i) disable iff (!rst_n || !ce_i)
    (!trdy_n_o && !cfg_reg) |-> stop_n_o)
    else $error("stop asserted on an I/O data clock");
  abort_show_a: assert property (@(posedge core_clk_i) disable iff (!rst_n || !ce_i)
    (state_reg == ABORT) |-> (!stop_n_o && !stop_oe_n_o && devsel_n_o && trdy_n_o))
    else $error("target abort not signalled");
  local_xfer_a: assert property (@(posedge core_clk_i) disable iff (!rst_n || !ce_i)
    (hs && local_reg) |=> (lt_xfer_o && !lt_sel_o))
    else $error("forwarded transfer not reported");
  single_phase_a: assert property (@(posedge core_clk_i) disable iff (!rst_n || !ce_i)
    hs |=> (trdy_n_o && state_reg == TURN))
    else $error("data phase continued after handshake");
  idle_quiet_a: assert property (@(posedge core_clk_i) disable iff (!rst_n || !ce_i)
    (state_reg == IDLE) |-> (devsel_oe_n_o && ad_oe_n_o && trdy_n_o))
    else $error("bus driven while idle");
  upper_wait_a: assert property (@(posedge core_clk_i) disable iff (!rst_n || !ce_i)
    (state_reg == DEVSEL && local_reg && !lt_ready_i && !lt_abort_i) |=> (state_reg == DEVSEL && trdy_n_o))
    else $error("forwarded access did not wait for the back-end");
  internal_fixed_a: assert property (@(posedge core_clk_i) disable iff (!rst_n || !ce_i)
    (state_reg == DEVSEL && !local_reg) |=> (!trdy_n_o && state_reg == DATA))
    else $error("internal header access did not complete on time");
  type_one_skip_a: assert property (@(posedge core_clk_i) disable iff (!rst_n || !ce_i)
    (addr_phase && idsel_f && cbe_f == pci_cfg_pkg::CMD_CFG_RD && ad_f[1:0] != 2'h0) |=> (state_reg == IDLE))
    else $error("non type-zero configuration access claimed");
endmodule : pci_target_cfg_io

// ---- verif/pci_host_model.sv ----
`timescale 1ns/1ps
module pci_host_model (
  // Clock.
  input wire logic clk_i,
  // Device outputs and enables, ordered devsel, trdy, stop.
  input wire logic [31:0] dev_ad_i,
  input wire logic dev_ad_oe_n_i,
  input wire logic [2:0] ctl_n_i,
  input wire logic [2:0] ctl_oe_n_i,
  // Resolved bus.
  output logic frame_n_o,
  output logic idsel_o,
  output logic irdy_n_o,
  output logic [3:0] cbe_n_o,
  output logic [31:0] ad_o,
  output logic [2:0] ctl_o
);
  logic [31:0] drv = 32'h0000_0000;
  logic [3:0] cbe = 4'h0;
  logic ad_en = 1'b0;
  logic cbe_en = 1'b0;
  initial begin
    frame_n_o = 1'b1;
    idsel_o = 1'b0;
    irdy_n_o = 1'b1;
  end
  // Released data and command lines show the inverse of the host's last loaded value and released control lines read high, so stale data never looks valid.
  assign ad_o = !dev_ad_oe_n_i ? dev_ad_i : ad_en ? drv : ~drv;
  assign cbe_n_o = cbe_en ? cbe : ~cbe;
  assign ctl_o = ctl_n_i | ctl_oe_n_i;
  task automatic xfer(input logic [3:0] cmd, input logic [31:0] a, d, input logic [3:0] be,
      input logic sel, output logic [31:0] rdata, output logic [2:0] resp, output logic rel);
    int n;
    resp = 3'h7;
    @(posedge clk_i);
    frame_n_o <= 1'b0;
    idsel_o <= sel;
    cbe <= cmd;
    cbe_en <= 1'b1;
    drv <= a;
    ad_en <= 1'b1;
    @(posedge clk_i);
    frame_n_o <= 1'b1;
    idsel_o <= 1'b0;
    irdy_n_o <= 1'b0;
    cbe <= be;
    drv <= d;
    ad_en <= cmd[pci_cfg_pkg::CMD_WRITE_BIT];
    for (n = 0; n < 30 && resp == 3'h7; n++) begin
      @(posedge clk_i);
      if (ctl_o[1] === 1'b0 || ctl_o[0] === 1'b0) resp = ctl_o;
    end
    rdata = ad_o;
    irdy_n_o <= 1'b1;
    ad_en <= 1'b0;
    cbe_en <= 1'b0;
    rel = 1'b1;
    if (resp[1] === 1'b0) begin
      @(posedge clk_i);
      rel = ctl_o === 3'h7 && ctl_oe_n_i === 3'h0 && dev_ad_oe_n_i === 1'b1;
      @(posedge clk_i);
      rel = rel && ctl_oe_n_i === 3'h7;
    end
    repeat (8) @(posedge clk_i);
  endtask : xfer
endmodule : pci_host_model

// ---- verif/pci_target_cfg_io_test.sv ----
`timescale 1ns/1ps
module pci_target_cfg_io_test;
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic frame_n, idsel, irdy_n, ad_oe_n, devsel_n, devsel_oe_n, trdy_n, trdy_oe_n, stop_n, stop_oe_n;
  logic [3:0] cbe_n, lt_be_n, x_be;
  logic [31:0] ad, dad, lt_addr, lt_wdata, rd, seen_addr, x_data;
  logic [31:0] lt_rdata = 32'h0000_0000;
  logic [23:0] io_base = 24'h00_0000;
  logic io_en = 1'b1;
  logic lt_ready = 1'b0;
  logic lt_abort = 1'b0;
  logic abort_mode = 1'b0;
  logic lt_sel, lt_io, lt_write, lt_xfer, seen_io, seen_wr, rel;
  logic [2:0] resp;
  logic [2:0] ctl;
  logic [31:0] ref_cfg [0:16];
  int failures, comparisons, dly, cnt, xfers, i, seed;
  always #25 core_clk_i = ~core_clk_i;
  pci_target_cfg_io pci_target_cfg_io_i (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .ce_i(1'b1),
    .frame_n_i(frame_n), .idsel_i(idsel), .irdy_n_i(irdy_n), .cbe_n_i(cbe_n), .ad_i(ad), .ad_o(dad),
    .ad_oe_n_o(ad_oe_n), .devsel_n_o(devsel_n), .devsel_oe_n_o(devsel_oe_n), .trdy_n_o(trdy_n),
    .trdy_oe_n_o(trdy_oe_n), .stop_n_o(stop_n), .stop_oe_n_o(stop_oe_n), .io_en_i(io_en),
    .io_base_i(io_base), .lt_sel_o(lt_sel), .lt_io_o(lt_io), .lt_write_o(lt_write), .lt_addr_o(lt_addr),
    .lt_be_n_o(lt_be_n), .lt_wdata_o(lt_wdata), .lt_xfer_o(lt_xfer), .lt_rdata_i(lt_rdata),
    .lt_ready_i(lt_ready), .lt_abort_i(lt_abort));
  pci_host_model pci_host_model_i (.clk_i(core_clk_i), .dev_ad_i(dad), .dev_ad_oe_n_i(ad_oe_n),
    .ctl_n_i({devsel_n, trdy_n, stop_n}), .ctl_oe_n_i({devsel_oe_n, trdy_oe_n, stop_oe_n}),
    .frame_n_o(frame_n), .idsel_o(idsel), .irdy_n_o(irdy_n), .cbe_n_o(cbe_n), .ad_o(ad), .ctl_o(ctl));
  // Back-end: answers after dly cycles, or aborts when asked to.
  always @(posedge core_clk_i) begin
    cnt <= lt_sel ? cnt + 1 : 0;
    lt_ready <= lt_sel && cnt >= dly && !abort_mode;
    lt_abort <= lt_sel && cnt >= dly && abort_mode;
    if (lt_sel && cnt == 0) begin
      seen_addr <= lt_addr;
      seen_io <= lt_io;
      seen_wr <= lt_write;
    end
    if (lt_xfer === 1'b1) begin
      xfers <= xfers + 1;
      x_data <= lt_wdata;
      x_be <= lt_be_n;
    end
  end
  task automatic check_data(input logic [31:0] got, want);
    comparisons++;
    if (got !== want) begin
      failures++;
      $display("wrong value at %0t: data %h expected %h", $time, got, want);
    end
  endtask : check_data
  task automatic check_code(input logic [3:0] got, want);
    comparisons++;
    if (got !== want) begin
      failures++;
      $display("wrong value at %0t: code %h expected %h", $time, got, want);
    end
  endtask : check_code
  task automatic print_verdict;
    if (failures == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  function automatic logic [31:0] cfg_addr(input int dw);
    logic [31:0] a;
    a = $urandom;
    a[7:0] = {dw[5:0], 2'b00};
    return a;
  endfunction : cfg_addr
  task automatic access(input logic [3:0] cmd, input logic [31:0] a, d, input logic [3:0] be,
      input logic sel, input logic [2:0] want);
    int n0;
    logic [31:0] ld;
    logic own;
    n0 = xfers;
    ld = $urandom;
    own = cmd[3] && a[7:2] <= pci_cfg_pkg::CFG_LAST_DW;
    lt_rdata <= ld;
    pci_host_model_i.xfer(cmd, a, d, be, sel, rd, resp, rel);
    check_code(4'(resp), 4'(want));
    check_code(4'(xfers - n0), 4'(!resp[1] && !own));
    if (!resp[1]) check_code(4'(rel), 4'h1);
    if (own && !resp[1] && cmd[0] && be == 4'h0) ref_cfg[a[6:2]] = d;
    if (own && !resp[1] && !cmd[0]) check_data(rd, ref_cfg[a[6:2]]);
    if (!own && !resp[1]) begin
      check_data(seen_addr, a);
      check_code({2'b00, seen_io, seen_wr}, {2'b00, !cmd[3], cmd[0]});
      check_data(cmd[0] ? x_data : rd, cmd[0] ? d : ld);
      if (cmd[0]) check_code(x_be, be);
    end
  endtask : access
  initial begin
    seed = $urandom(32'hF6AC);
    repeat (5) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    io_base <= 24'($urandom);
    repeat (8) @(posedge core_clk_i);
    for (i = 0; i <= 16; i++) access(pci_cfg_pkg::CMD_CFG_WR, cfg_addr(i), $urandom, 4'h0, 1'b1, 3'h0);
    for (i = 0; i < 8; i++) access(pci_cfg_pkg::CMD_CFG_WR, cfg_addr($urandom_range(16)), $urandom,
      4'($urandom_range(15, 1)), 1'b1, 3'h0);
    for (i = 0; i <= 16; i++) access(pci_cfg_pkg::CMD_CFG_RD, cfg_addr(i), 32'h0, 4'h0, 1'b1, 3'h0);
    for (i = 0; i < 6; i++) begin
      dly <= $urandom_range(3);
      access(i[0] ? pci_cfg_pkg::CMD_CFG_WR : pci_cfg_pkg::CMD_CFG_RD, cfg_addr($urandom_range(63, 17)),
        $urandom, 4'h0, 1'b1, 3'h0);
    end
    access(pci_cfg_pkg::CMD_CFG_RD, cfg_addr(2), 32'h0, 4'h0, 1'b0, 3'h7);
    access(pci_cfg_pkg::CMD_CFG_RD, cfg_addr(2) | 32'h1, 32'h0, 4'h0, 1'b1, 3'h7);
    for (i = 0; i < 4; i++) access(i[0] ? pci_cfg_pkg::CMD_IO_WR : pci_cfg_pkg::CMD_IO_RD,
      {io_base, 8'($urandom)}, $urandom, 4'($urandom), 1'b0, 3'h1);
    access(pci_cfg_pkg::CMD_IO_RD, {~io_base, 8'h00}, 32'h0, 4'h0, 1'b0, 3'h7);
    io_en <= 1'b0;
    access(pci_cfg_pkg::CMD_IO_RD, {io_base, 8'h04}, 32'h0, 4'h0, 1'b0, 3'h7);
    io_en <= 1'b1;
    abort_mode <= 1'b1;
    access(pci_cfg_pkg::CMD_IO_WR, {io_base, 8'h08}, $urandom, 4'h5, 1'b0, 3'h6);
    print_verdict();
  end
  // The whole sequence needs about 1000 cycles.
  initial begin
    repeat (10000) @(posedge core_clk_i);
    failures++;
    print_verdict();
  end
endmodule : pci_target_cfg_io_test
